// *** shared/dprtk_cfg.svh ***
`ifndef DPRTK_CFG_SVH
`define DPRTK_CFG_SVH
`define DPRTK_CLK_NS 5
`define DPRTK_ADDR_W 17
`define DPRTK_DATA_W 9
`define DPRTK_TRC_NS 25
`define DPRTK_TPWE_NS 22
`define DPRTK_TSD_NS 15
`define DPRTK_THZWE_NS 15
`define DPRTK_TDOE_NS 13
`define DPRTK_TOKEN_UPDATE_GAP_NS 12
`define DPRTK_TOKEN_WRITE_TO_READ_TIME_NS 5
`define DPRTK_TAA_NS 25
`define DPRTK_CYC(ns) (((ns) + `DPRTK_CLK_NS - 1) / `DPRTK_CLK_NS)
`define DPRTK_PULSE_CYC `DPRTK_CYC(`DPRTK_THZWE_NS + `DPRTK_TSD_NS)
`define DPRTK_PULSE_OFF_CYC `DPRTK_CYC(`DPRTK_TPWE_NS)
`define DPRTK_GAP_CYC `DPRTK_CYC(`DPRTK_TOKEN_UPDATE_GAP_NS)
`define DPRTK_READ_CYC `DPRTK_CYC(`DPRTK_TAA_NS + `DPRTK_TOKEN_WRITE_TO_READ_TIME_NS + `DPRTK_TDOE_NS)
`define DPRTK_PWRUP_CYC (`DPRTK_CYC(`DPRTK_TRC_NS) + 1)
`define DPRTK_CNT_W 4
`endif

// *** shared/dprtk_pkg.sv ***
package dprtk_pkg;
  typedef enum logic [1:0] {
    DPRTK_OP_RAM_RD = 2'h0,
    DPRTK_OP_RAM_WR = 2'h1,
    DPRTK_OP_TOK_RD = 2'h2,
    DPRTK_OP_TOK_WR = 2'h3
  } dprtk_op_type;
  typedef enum logic [2:0] {
    DPRTK_ST_IDLE = 3'h0,
    DPRTK_ST_SETUP = 3'h1,
    DPRTK_ST_STROBE = 3'h3,
    DPRTK_ST_GAP = 3'h2,
    DPRTK_ST_RETAIN = 3'h6
  } dprtk_state_type;
endpackage : dprtk_pkg

// *** design/dprtk_timer.sv ***
`timescale 1ns/100ps
`include "dprtk_cfg.svh"
module dprtk_timer
  import dprtk_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [`DPRTK_CNT_W-1:0] value_i,
  output logic done_o
);
  logic [`DPRTK_CNT_W-1:0] cnt_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= 4'h0;
    end else if (load_i) begin
      cnt_r <= value_i;
    end else if (cnt_r != 4'h0) begin
      cnt_r <= cnt_r - 4'h1;
    end
  end
  assign done_o = (cnt_r == 4'h0);
endmodule : dprtk_timer

// *** design/dprtk_host.sv ***
`timescale 1ns/100ps
`include "dprtk_cfg.svh"
module dprtk_host
  import dprtk_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire dprtk_op_type req_op_i,
  input wire logic [`DPRTK_ADDR_W-1:0] req_addr_i,
  input wire logic [`DPRTK_DATA_W-1:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic [`DPRTK_DATA_W-1:0] rsp_rdata_o,
  input wire logic retain_i,
  output logic retain_o,
  input wire logic mailbox_flag_n_i,
  output logic mailbox_flag_o,
  output logic [`DPRTK_ADDR_W-1:0] addr_o,
  output logic port_select_n_o,
  output logic upper_byte_select_n_o,
  output logic token_latch_select_n_o,
  output logic write_strobe_n_o,
  output logic output_drive_enable_n_o,
  output logic [`DPRTK_DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire logic [`DPRTK_DATA_W-1:0] data_i
);
  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [`DPRTK_DATA_W-1:0] data_s1_r;
  logic [`DPRTK_DATA_W-1:0] data_s2_r;
  logic flag_s1_r;
  logic flag_s2_r;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      data_s1_r <= 9'h000;
      data_s2_r <= 9'h000;
      flag_s1_r <= 1'h1;
      flag_s2_r <= 1'h1;
    end else begin
      data_s1_r <= data_i;
      data_s2_r <= data_s1_r;
      flag_s1_r <= mailbox_flag_n_i;
      flag_s2_r <= flag_s1_r;
    end
  end
  assign mailbox_flag_o = !flag_s2_r;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  function automatic logic is_write(input dprtk_op_type op);
    is_write = (op == DPRTK_OP_RAM_WR) || (op == DPRTK_OP_TOK_WR);
  endfunction : is_write
  function automatic logic is_token(input dprtk_op_type op);
    is_token = (op == DPRTK_OP_TOK_RD) || (op == DPRTK_OP_TOK_WR);
  endfunction : is_token
  function automatic logic is_read(input dprtk_op_type op);
    is_read = !is_write(op);
  endfunction : is_read
  // Only a token write needs the long update gap before the next access
  function automatic logic [`DPRTK_CNT_W-1:0] gap_len(input dprtk_op_type op);
    if (is_token(op) && is_write(op)) begin
      gap_len = 4'(`DPRTK_GAP_CYC);
    end else begin
      gap_len = 4'h1;
    end
  endfunction : gap_len

  dprtk_state_type state_r;
  dprtk_op_type op_r;
  logic load;
  logic [`DPRTK_CNT_W-1:0] load_val;
  logic done;

  dprtk_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .load_i(load),
    .value_i(load_val),
    .done_o(done)
  );

  assign req_ready_o = (state_r == DPRTK_ST_IDLE) && done && !retain_i;
  assign retain_o = (state_r == DPRTK_ST_RETAIN);

  always_comb begin
    load = 1'b0;
    load_val = 4'h0;
    case (state_r)
      DPRTK_ST_IDLE: begin
        if (req_valid_i && req_ready_o) begin
          load = 1'b1;
          load_val = 4'h1;
        end
      end
      DPRTK_ST_SETUP: begin
        load = 1'b1;
        if (is_read(op_r)) begin
          load_val = 4'(`DPRTK_READ_CYC);
        end else if (is_token(op_r)) begin
          load_val = 4'(`DPRTK_PULSE_OFF_CYC);
        end else begin
          load_val = 4'(`DPRTK_PULSE_CYC);
        end
      end
      DPRTK_ST_STROBE: begin
        if (done) begin
          load = 1'b1;
          load_val = gap_len(op_r);
        end
      end
      DPRTK_ST_RETAIN: begin
        if (!retain_i) begin
          load = 1'b1;
          load_val = 4'(`DPRTK_PWRUP_CYC);
        end
      end
      default: begin
        load = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= DPRTK_ST_IDLE;
      op_r <= DPRTK_OP_RAM_RD;
      addr_o <= 17'h00000;
      data_o <= 9'h000;
    end else begin
      case (state_r)
        DPRTK_ST_IDLE: begin
          if (retain_i && done) begin
            state_r <= DPRTK_ST_RETAIN;
          end else if (req_valid_i && req_ready_o) begin
            op_r <= req_op_i;
            addr_o <= is_token(req_op_i) ? {14'h0000, req_addr_i[2:0]} : req_addr_i;
            data_o <= req_wdata_i;
            state_r <= DPRTK_ST_SETUP;
          end
        end
        DPRTK_ST_SETUP: state_r <= DPRTK_ST_STROBE;
        DPRTK_ST_STROBE: begin
          if (done) begin
            state_r <= DPRTK_ST_GAP;
          end
        end
        DPRTK_ST_GAP: begin
          if (done) begin
            state_r <= DPRTK_ST_IDLE;
          end
        end
        DPRTK_ST_RETAIN: begin
          if (!retain_i) begin
            state_r <= DPRTK_ST_IDLE;
          end
        end
        default: state_r <= DPRTK_ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pin drive
  // ----------------------------------------------------------------
  logic active;
  logic ram_sel_nxt;
  logic tok_sel_nxt;
  logic strobe_nxt;
  logic drive_nxt;
  logic data_oe_nxt;
  assign active = (state_r == DPRTK_ST_STROBE);

  // Pins go low only while strobing and return high on the phase end
  always_comb begin
    ram_sel_nxt = 1'b0;
    tok_sel_nxt = 1'b0;
    strobe_nxt = 1'b0;
    drive_nxt = 1'b0;
    data_oe_nxt = (state_r == DPRTK_ST_SETUP || active) && is_write(op_r);
    if (active && !load) begin
      ram_sel_nxt = !is_token(op_r);
      tok_sel_nxt = is_token(op_r);
      strobe_nxt = is_write(op_r);
      drive_nxt = is_read(op_r);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      port_select_n_o <= 1'b1;
      upper_byte_select_n_o <= 1'b1;
      token_latch_select_n_o <= 1'b1;
      write_strobe_n_o <= 1'b1;
      output_drive_enable_n_o <= 1'b1;
      data_oe_o <= 1'b0;
    end else begin
      port_select_n_o <= !ram_sel_nxt;
      upper_byte_select_n_o <= !ram_sel_nxt;
      token_latch_select_n_o <= !tok_sel_nxt;
      write_strobe_n_o <= !strobe_nxt;
      output_drive_enable_n_o <= !drive_nxt;
      data_oe_o <= data_oe_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Read capture
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rsp_valid_o <= 1'b0;
      rsp_rdata_o <= 9'h000;
    end else begin
      rsp_valid_o <= 1'b0;
      if (state_r == DPRTK_ST_GAP && done && is_read(op_r)) begin
        rsp_valid_o <= 1'b1;
        rsp_rdata_o <= data_s2_r;
      end
    end
  end
endmodule : dprtk_host

// *** testbench/dprtk_host_asserts.sv ***
`timescale 1ns/100ps
`include "dprtk_cfg.svh"
// ----
// Pin order checks
// ----
module dprtk_host_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic retain_i,
  input wire logic retain_o,
  input wire logic [`DPRTK_ADDR_W-1:0] addr_o,
  input wire logic port_select_n_o,
  input wire logic upper_byte_select_n_o,
  input wire logic token_latch_select_n_o,
  input wire logic write_strobe_n_o,
  input wire logic data_oe_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ram_sel_ok:
    assert property (!port_select_n_o |-> !upper_byte_select_n_o && token_latch_select_n_o)
    else $error("ram select mix");
  a_tok_sel_ok:
    assert property (!token_latch_select_n_o |-> port_select_n_o) else $error("token select mix");
  a_addr_hold:
    assert property (!write_strobe_n_o |-> $stable(addr_o)) else $error("address moved");
  a_read_no_strobe:
    assert property (!write_strobe_n_o |-> data_oe_o) else $error("strobe without data");
  a_pulse_width:
    assert property ($fell(write_strobe_n_o) |-> !write_strobe_n_o [*5]) else $error("short pulse");
  a_token_gap:
    assert property ($rose(token_latch_select_n_o) && !$past(write_strobe_n_o)
      |-> token_latch_select_n_o [*3]) else $error("token gap short");
  a_retain_idle:
    assert property (retain_o |-> port_select_n_o && token_latch_select_n_o)
    else $error("select in retention");
  a_wake_wait:
    assert property ($fell(retain_i) |-> port_select_n_o [*6]) else $error("early access");
endmodule : dprtk_host_asserts

// *** testbench/dprtk_dev_model.sv ***
`timescale 1ns/100ps
// ----
// Device port model
// ----
module dprtk_dev_model (
  input wire logic clk_i,
  input wire logic [16:0] a_i,
  input wire logic cs_n_i,
  input wire logic upper_byte_select_n_i,
  input wire logic token_latch_select_n_i,
  input wire logic we_n_i,
  input wire logic oe_n_i,
  input wire logic [8:0] d_i,
  input wire logic [7:0] far_own_i,
  output logic [8:0] d_o
);
  logic [8:0] mem [0:131071];
  logic [7:0] own_r = 8'h00;
  logic flip_r = 1'b0;
  wire ram = !cs_n_i && !upper_byte_select_n_i && token_latch_select_n_i;
  wire tok = cs_n_i && !token_latch_select_n_i;
  wire rd = we_n_i && !oe_n_i && (ram || tok);
  always @(posedge clk_i) flip_r <= ~flip_r;
  always @* if (!we_n_i && ram) mem[a_i] = d_i;
  always @* if (!we_n_i && tok) own_r[a_i[2:0]] = !d_i[0] && !far_own_i[a_i[2:0]];
  assign d_o = !rd ? (flip_r ? 9'h155 : 9'h0aa) :
    ram ? mem[a_i] : {9{!own_r[a_i[2:0]]}};
endmodule : dprtk_dev_model

// *** testbench/dprtk_host_tb_top.sv ***
`timescale 1ns/100ps
module dprtk_host_tb_top;
  import dprtk_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic vld = 1'b0, ret = 1'b0, mfn = 1'b1, rdy, rv, ro, mf, ps, ub, ts, ws, oe, doe;
  dprtk_op_type op = DPRTK_OP_RAM_RD;
  logic [16:0] ad = 17'h00000, ao;
  logic [8:0] wd = 9'h000, rd, hd, md;
  logic [7:0] far = 8'h00;
  logic [8:0] eq [$];
  int seed = 45477, n_errors = 0, checks_done = 0;
  wire [8:0] bus = doe ? hd : md;
  always #2.5 clk_i = ~clk_i;
  dprtk_host uut (.clk_i(clk_i), .rst_i(rst_i), .req_valid_i(vld), .req_ready_o(rdy),
    .req_op_i(op), .req_addr_i(ad), .req_wdata_i(wd), .rsp_valid_o(rv), .rsp_rdata_o(rd),
    .retain_i(ret), .retain_o(ro), .mailbox_flag_n_i(mfn), .mailbox_flag_o(mf), .addr_o(ao),
    .port_select_n_o(ps), .upper_byte_select_n_o(ub), .token_latch_select_n_o(ts),
    .write_strobe_n_o(ws), .output_drive_enable_n_o(oe), .data_o(hd), .data_oe_o(doe), .data_i(bus));
  dprtk_dev_model dev (.clk_i(clk_i), .a_i(ao), .cs_n_i(ps), .upper_byte_select_n_i(ub),
    .token_latch_select_n_i(ts), .we_n_i(ws), .oe_n_i(oe), .d_i(hd), .far_own_i(far), .d_o(md));
  task automatic chk(input string nm, input logic [8:0] seen, input logic [8:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic req(input dprtk_op_type o, input logic [16:0] a, input logic [8:0] d,
    input logic [8:0] e);
    @(negedge clk_i);
    op = o;
    ad = a;
    wd = d;
    vld = 1'b1;
    if (!o[0]) eq.push_back(e);
    while (rdy !== 1'b1) @(negedge clk_i);
    @(negedge clk_i);
    vld = 1'b0;
  endtask : req
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out
  always @(negedge clk_i) if (rv === 1'b1) chk("rdata", rd, eq.size() ? eq.pop_front() : 9'hx);
  initial begin
    logic [16:0] a;
    logic [8:0] v;
    repeat (8) @(negedge clk_i);
    rst_i = 1'b0;
    for (int i = 0; i < 6; i++) begin
      a = {1'b0, 16'($random(seed))};
      v = 9'($random(seed));
      req(DPRTK_OP_RAM_WR, a, v, 9'h000);
      req(DPRTK_OP_RAM_RD, a, 9'h000, v);
    end
    $display("test ram done");
    far = 8'h08;
    for (int k = 0; k < 8; k++) begin
      a = {14'($random(seed)), 3'(k)};
      req(DPRTK_OP_TOK_WR, a, 9'h000, 9'h000);
      req(DPRTK_OP_TOK_RD, a, 9'h000, k == 3 ? 9'h1ff : 9'h000);
      req(DPRTK_OP_TOK_WR, a, 9'h001, 9'h000);
      req(DPRTK_OP_TOK_RD, a, 9'h000, 9'h1ff);
    end
    $display("test token done");
    req(DPRTK_OP_RAM_WR, 17'h1fffe, 9'h05a, 9'h000);
    mfn = 1'b0;
    repeat (4) @(negedge clk_i);
    chk("flag", {8'h00, mf}, 9'h001);
    mfn = 1'b1;
    repeat (4) @(negedge clk_i);
    chk("flag", {8'h00, mf}, 9'h000);
    ret = 1'b1;
    repeat (20) @(negedge clk_i);
    chk("retain", {8'h00, ro}, 9'h001);
    ret = 1'b0;
    req(DPRTK_OP_RAM_RD, 17'h1fffe, 9'h000, 9'h05a);
    repeat (40) @(negedge clk_i);
    $display("test retain done");
    close_out();
  end
  initial begin
    #40000;
    n_errors++;
    close_out();
  end
endmodule : dprtk_host_tb_top
bind dprtk_host dprtk_host_asserts u_chk (.*);
